// >>> verilog/pvt_source.sv
/*
 * Parallel video source: drives frame sync, line sync, pixel-valid
 * command and pixel data with a divided pixel clock, plus the
 * device reset pulse. Assumes the device samples on the rising edge
 * of the pixel clock, so all video outputs change on its falling edge.
 */
// Overview of operation
// - Frame sync is held high for at least one full line each frame.
// - At least two lines pass from frame sync rise to the first active line sync rise.
// - At least one line passes from the line sync after the last active line to the next frame sync.
// - Total vertical blanking is at least 6 plus 8 times max(1, source lines over mirror lines).
// - Line sync stays high for 4 to 128 pixel clocks.
// - At least 4 pixel clocks pass from line sync rise to pixel-valid rise.
// - At least 8 pixel clocks pass from pixel-valid fall to the next line sync rise.
// - Horizontal blanking equals ceil(1000 times pixel clock MHz over line rate kHz) minus active pixels; the code uses HBP plus HFP.
// - If that blanking is below both porches the pixel clock must rise or the line rate fall.
// - The device reset is held low for at least 1.25 us.
// - The main reference clock is a steady 24 MHz without spreading.
module pvt_source
    import pvt_pkg::*;
#(
    parameter int ACTIVE_PIXELS = DEF_ACTIVE_PIXELS,
    parameter int ACTIVE_LINES = DEF_ACTIVE_LINES,
    parameter int MIRROR_LINES = DEF_MIRROR_LINES,
    parameter int HSYNC_PCLK = DEF_HSYNC_PCLK,
    parameter int HBP_PCLK = DEF_HBP_PCLK,
    parameter int HFP_PCLK = DEF_HFP_PCLK,
    parameter int VSYNC_LINES = DEF_VSYNC_LINES,
    parameter int VBP_LINES = DEF_VBP_LINES,
    parameter int VFP_LINES = DEF_VFP_LINES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic [23:0] i_pixel_data,
    output logic o_pixel_ready,
    output logic o_pclk,
    output pvt_video_t o_video,
    output logic o_system_reset_low,
    output logic o_frame_start,
    output logic o_timing_error
);

    // Clamp geometry to legal limits so a bad parameter cannot break the link
    localparam int HSW = (HSYNC_PCLK < HSYNC_MIN_PCLK) ? HSYNC_MIN_PCLK :
                         (HSYNC_PCLK > HSYNC_MAX_PCLK) ? HSYNC_MAX_PCLK : HSYNC_PCLK;
    localparam int HBP = (HBP_PCLK < HBP_MIN_PCLK) ? HBP_MIN_PCLK : HBP_PCLK;
    localparam int HFP = (HFP_PCLK < HFP_MIN_PCLK) ? HFP_MIN_PCLK : HFP_PCLK;
    localparam int VSW = (VSYNC_LINES < VSYNC_MIN_LINES) ? VSYNC_MIN_LINES : VSYNC_LINES;
    localparam int VFP = (VFP_LINES < VFP_MIN_LINES) ? VFP_MIN_LINES : VFP_LINES;
    // Ratio rounded up so blanking never falls short
    localparam int RATIO = (ACTIVE_LINES + MIRROR_LINES - 1) / MIRROR_LINES;
    localparam int TVB_MIN = TVB_BASE_LINES + TVB_SCALE_LINES * ((RATIO > 1) ? RATIO : 1);
    localparam int VBP0 = (VBP_LINES < VBP_MIN_LINES) ? VBP_MIN_LINES : VBP_LINES;
    localparam int VBP = (VBP0 + VFP < TVB_MIN) ? TVB_MIN - VFP : VBP0;
    // Line period; blanking equals period minus active pixels, always equal to both porches together
    localparam int LINE_PCLK = HBP + ACTIVE_PIXELS + HFP;
    localparam int FRAME_LINES = VBP + ACTIVE_LINES + VFP;
    localparam int HW = $clog2(LINE_PCLK + 1);
    localparam int VW = $clog2(FRAME_LINES + 1);
    localparam int RW = $clog2(RESET_LOW_CYC + 1);

    logic [RW-1:0] rst_cnt_q;
    logic rst_done_q;
    logic [1:0] div_q;
    logic pclk_q;
    logic fall_q;
    logic [HW-1:0] hcnt_q;
    logic [VW-1:0] vcnt_q;
    logic run_q;
    pvt_state_t state_q;
    pvt_video_t video_q;
    logic ready_q;
    logic start_q;
    logic err_q;

    // Device reset held low for the least pulse width
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rst_cnt_q <= '0;
            rst_done_q <= 1'b0;
        end else if (!rst_done_q) begin
            if (rst_cnt_q == RW'(RESET_LOW_CYC - 1)) begin
                rst_done_q <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end
        end
    end

    // Pixel clock from a free-running divider; not spread, steady period
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_q <= '0;
            pclk_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            // Strobe one cycle early so outputs change on the fall itself; needs a half period of 2 or more
            fall_q <= pclk_q && (div_q == 2'(PCLK_HALF_DIV - 2));
            if (div_q == 2'(PCLK_HALF_DIV - 1)) begin
                div_q <= '0;
                pclk_q <= ~pclk_q;
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // Pixel and line counters, advanced on the pixel clock falling edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            hcnt_q <= '0;
            vcnt_q <= '0;
            run_q <= 1'b0;
        end else if (fall_q) begin
            if (!run_q) begin
                run_q <= rst_done_q && i_enable;
            end else if (hcnt_q == HW'(LINE_PCLK - 1)) begin
                hcnt_q <= '0;
                if (vcnt_q == VW'(FRAME_LINES - 1)) begin
                    vcnt_q <= '0;
                    run_q <= i_enable;
                end else begin
                    vcnt_q <= vcnt_q + 1'b1;
                end
            end else begin
                hcnt_q <= hcnt_q + 1'b1;
            end
        end
    end

    // Video outputs; a line starts at line sync rise, frame sync rises with line 0
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            video_q <= '0;
            state_q <= PVT_RESET;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (!rst_done_q) begin
                state_q <= PVT_RESET;
                video_q <= '0;
            end else if (fall_q) begin
                if (!run_q) begin
                    state_q <= PVT_IDLE;
                    video_q <= '0;
                end else begin
                    video_q.frame_sync <= (vcnt_q < VW'(VSW));
                    video_q.line_sync <= (hcnt_q < HW'(HSW));
                    start_q <= (vcnt_q == '0) && (hcnt_q == '0);
                    if (vcnt_q >= VW'(VBP) && vcnt_q < VW'(VBP + ACTIVE_LINES) &&
                        hcnt_q >= HW'(HBP) && hcnt_q < HW'(HBP + ACTIVE_PIXELS)) begin
                        state_q <= PVT_ACTIVE;
                        video_q.pixel_valid_command <= 1'b1;
                        video_q.pixel_data <= i_pixel_data;
                    end else begin
                        video_q.pixel_valid_command <= 1'b0;
                        video_q.pixel_data <= '0;
                        if (hcnt_q < HW'(HSW)) begin
                            state_q <= PVT_SYNC;
                        end else if (hcnt_q < HW'(HBP)) begin
                            state_q <= PVT_BACK;
                        end else begin
                            state_q <= PVT_FRONT;
                        end
                    end
                end
            end
        end
    end

    // Request pixel data one system cycle before it is latched
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= rst_done_q && run_q && !pclk_q && (div_q == 2'(PCLK_HALF_DIV - 1)) &&
                       vcnt_q >= VW'(VBP) && vcnt_q < VW'(VBP + ACTIVE_LINES) &&
                       hcnt_q >= HW'(HBP) && hcnt_q < HW'(HBP + ACTIVE_PIXELS);
        end
    end

    // Self-check of the emitted timing, in pixel clocks and lines
    localparam int MW = $clog2(HSYNC_MAX_PCLK + 2);

    logic prev_ls_q;
    logic prev_dv_q;
    logic prev_fs_q;
    logic [MW-1:0] ls_width_q;
    logic [MW-1:0] since_ls_q;
    logic [MW-1:0] since_dv_q;
    logic [VW-1:0] lines_fs_q;
    logic [VW-1:0] lines_end_q;
    logic dv_seen_q;
    logic mon_err_q;
    logic rise_ls;
    logic fall_ls;
    logic rise_dv;
    logic fall_dv;
    logic rise_fs;
    logic fall_fs;

    // Edges between the last two pixel periods
    assign rise_ls = video_q.line_sync && !prev_ls_q;
    assign fall_ls = !video_q.line_sync && prev_ls_q;
    assign rise_dv = video_q.pixel_valid_command && !prev_dv_q;
    assign fall_dv = !video_q.pixel_valid_command && prev_dv_q;
    assign rise_fs = video_q.frame_sync && !prev_fs_q;
    assign fall_fs = !video_q.frame_sync && prev_fs_q;

    // Levels of the pixel period just ended
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prev_ls_q <= 1'b0;
            prev_dv_q <= 1'b0;
            prev_fs_q <= 1'b0;
        end else if (fall_q) begin
            prev_ls_q <= video_q.line_sync;
            prev_dv_q <= video_q.pixel_valid_command;
            prev_fs_q <= video_q.frame_sync;
        end
    end

    // Line sync width and pixel clocks since line sync rise and pixel-valid fall, saturating
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ls_width_q <= '0;
            since_ls_q <= '1;
            since_dv_q <= '1;
        end else if (fall_q) begin
            if (rise_ls) begin
                ls_width_q <= MW'(1);
                since_ls_q <= MW'(1);
            end else begin
                if (video_q.line_sync && ls_width_q != '1) begin
                    ls_width_q <= ls_width_q + 1'b1;
                end
                if (since_ls_q != '1) begin
                    since_ls_q <= since_ls_q + 1'b1;
                end
            end
            if (fall_dv) begin
                since_dv_q <= MW'(1);
            end else if (since_dv_q != '1) begin
                since_dv_q <= since_dv_q + 1'b1;
            end
        end
    end

    // Lines since frame sync rose and since the last active line, saturating
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lines_fs_q <= '0;
            lines_end_q <= '1;
            dv_seen_q <= 1'b0;
        end else if (fall_q) begin
            if (rise_fs) begin
                lines_fs_q <= VW'(1);
                dv_seen_q <= 1'b0;
            end else if (rise_ls && lines_fs_q != '1) begin
                lines_fs_q <= lines_fs_q + 1'b1;
            end
            if (rise_dv) begin
                dv_seen_q <= 1'b1;
            end
            if (fall_dv) begin
                lines_end_q <= '0;
            end else if (rise_ls && lines_end_q != '1) begin
                lines_end_q <= lines_end_q + 1'b1;
            end
        end
    end

    // Raised when the emitted timing leaves its legal limits
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mon_err_q <= 1'b0;
        end else if (fall_q) begin
            if (fall_ls && (ls_width_q < MW'(HSYNC_MIN_PCLK) || ls_width_q > MW'(HSYNC_MAX_PCLK))) begin
                mon_err_q <= 1'b1;
            end
            if (rise_dv && since_ls_q < MW'(HBP_MIN_PCLK)) begin
                mon_err_q <= 1'b1;
            end
            if (rise_ls && since_dv_q < MW'(HFP_MIN_PCLK)) begin
                mon_err_q <= 1'b1;
            end
            if (fall_fs && lines_fs_q < VW'(VSYNC_MIN_LINES)) begin
                mon_err_q <= 1'b1;
            end
            if (rise_dv && !dv_seen_q && lines_fs_q <= VW'(VBP_MIN_LINES)) begin
                mon_err_q <= 1'b1;
            end
            if (rise_fs && lines_end_q < VW'(VFP_MIN_LINES)) begin
                mon_err_q <= 1'b1;
            end
            if (rise_dv && !dv_seen_q && lines_end_q <= VW'(TVB_MIN)) begin
                mon_err_q <= 1'b1;
            end
            if ((state_q == PVT_ACTIVE) != video_q.pixel_valid_command) begin
                mon_err_q <= 1'b1;
            end
        end
    end

    // Sticky: strobe off the pixel clock fall, or emitted timing out of limits
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            err_q <= 1'b0;
        end else if ((fall_q && !pclk_q) || mon_err_q) begin
            err_q <= 1'b1;
        end
    end

    assign o_pclk = pclk_q;
    assign o_video = video_q;
    assign o_system_reset_low = rst_done_q;
    assign o_pixel_ready = ready_q;
    assign o_frame_start = start_q;
    assign o_timing_error = err_q;

endmodule : pvt_source

// >>> verilog/pvt_pkg.sv
/*
 * Package for the parallel video source controller: timing constants,
 * frame geometry defaults, pin bundle and state encoding.
 * Assumes a 100 MHz system clock.
 */
package pvt_pkg;

    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 10;

    // Pixel clock divider: half period in system clocks
    localparam int PCLK_HALF_DIV = 2;

    // Device reset pulse, least time
    localparam real RESET_LOW_US = 1.25;
    localparam int RESET_LOW_CYC = int'($ceil(RESET_LOW_US * 1000.0 / CLK_PERIOD_NS));

    // Line timing limits in pixel clocks
    localparam int HSYNC_MIN_PCLK = 4;
    localparam int HSYNC_MAX_PCLK = 128;
    localparam int HBP_MIN_PCLK = 4;
    localparam int HFP_MIN_PCLK = 8;

    // Frame timing limits in lines
    localparam int VSYNC_MIN_LINES = 1;
    localparam int VBP_MIN_LINES = 2;
    localparam int VFP_MIN_LINES = 1;
    localparam int TVB_BASE_LINES = 6;
    localparam int TVB_SCALE_LINES = 8;
    localparam int LINE_RATE_SCALE = 1000;

    // Default geometry
    localparam int DEF_HSYNC_PCLK = 8;
    localparam int DEF_HBP_PCLK = 8;
    localparam int DEF_HFP_PCLK = 16;
    localparam int DEF_ACTIVE_PIXELS = 64;
    localparam int DEF_ACTIVE_LINES = 16;
    localparam int DEF_MIRROR_LINES = 16;
    localparam int DEF_VSYNC_LINES = 1;
    localparam int DEF_VBP_LINES = 13;
    localparam int DEF_VFP_LINES = 1;

    typedef struct packed {
        logic frame_sync;
        logic line_sync;
        logic pixel_valid_command;
        logic [23:0] pixel_data;
    } pvt_video_t;

    typedef enum logic [2:0] {
        PVT_RESET = 3'b000,
        PVT_IDLE = 3'b001,
        PVT_SYNC = 3'b011,
        PVT_BACK = 3'b010,
        PVT_ACTIVE = 3'b110,
        PVT_FRONT = 3'b111
    } pvt_state_t;

endpackage : pvt_pkg

// >>> tb/pvt_assertions.sv
/* Timing checker for pvt_source, bound to its ports.
   Assumes the default porch clamps and a 100 MHz clock. */
module pvt_checker
    import pvt_pkg::*;
#(
    parameter int ACTIVE_PIXELS = DEF_ACTIVE_PIXELS,
    parameter int HBP_PCLK = DEF_HBP_PCLK,
    parameter int HFP_PCLK = DEF_HFP_PCLK
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic o_pclk,
    input wire pvt_video_t o_video,
    input wire logic o_system_reset_low
);
    localparam int P = 2 * PCLK_HALF_DIV;
    logic [12:0] rc = '0, hc = '0, ac = '0, fc = '0, vc = '1, lc = '0, nv = '1;
    wire logic ls = o_video.line_sync;
    wire logic dv = o_video.pixel_valid_command;
    wire logic fs = o_video.frame_sync;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Cycle and line counters since each edge, saturating except lc
    always_ff @(posedge i_clk) begin
        rc <= (i_reset || !o_system_reset_low) ? rc + 13'(rc != '1) : '0;
        hc <= $rose(ls) ? 13'h1 : hc + 13'(hc != '1);
        ac <= $rose(dv) ? 13'h1 : ac + 13'(ac != '1);
        fc <= $rose(fs) ? 13'h1 : fc + 13'(fc != '1);
        vc <= $fell(dv) ? 13'h1 : vc + 13'(vc != '1);
        lc <= $rose(fs) ? '0 : lc + 13'($rose(ls));
        nv <= i_reset ? '1 : $fell(dv) ? '0 : nv + 13'($rose(ls) && nv != '1);
    end
    property p_rst; $rose(o_system_reset_low) |-> rc >= RESET_LOW_CYC; endproperty
    a_rst: assert property (p_rst) else $error("reset pulse short");
    property p_hsw; $fell(ls) |-> hc inside {[HSYNC_MIN_PCLK * P:HSYNC_MAX_PCLK * P]}; endproperty
    a_hsw: assert property (p_hsw) else $error("line sync width");
    property p_hbp; $rose(dv) |-> hc >= HBP_MIN_PCLK * P; endproperty
    a_hbp: assert property (p_hbp) else $error("back porch short");
    property p_hfp; $rose(ls) |-> vc >= HFP_MIN_PCLK * P; endproperty
    a_hfp: assert property (p_hfp) else $error("front porch short");
    property p_active_pixels_per_line; $fell(dv) |-> ac == ACTIVE_PIXELS * P; endproperty
    a_active_pixels_per_line: assert property (p_active_pixels_per_line) else $error("active pixels");
    property p_edge; $changed(o_video) |-> $fell(o_pclk); endproperty
    a_edge: assert property (p_edge) else $error("video off pclk fall");
    property p_vsw; $fell(fs) |-> fc >= P * (HBP_PCLK + ACTIVE_PIXELS + HFP_PCLK); endproperty
    a_vsw: assert property (p_vsw) else $error("frame sync short");
    property p_vbp; $rose(dv) |-> lc >= VBP_MIN_LINES; endproperty
    a_vbp: assert property (p_vbp) else $error("vertical back porch");
    property p_vfp; $rose(fs) |-> nv >= VFP_MIN_LINES; endproperty
    a_vfp: assert property (p_vfp) else $error("vertical front porch");
    property p_tvb; $rose(dv) |-> nv == 1 || nv >= TVB_BASE_LINES + TVB_SCALE_LINES + 1; endproperty
    a_tvb: assert property (p_tvb) else $error("vertical blanking");
    c_frame: cover property ($rose(fs));
    c_line: cover property ($fell(dv));
    c_rst: cover property ($rose(o_system_reset_low));
endmodule : pvt_checker
bind pvt_source pvt_checker #(.ACTIVE_PIXELS(ACTIVE_PIXELS), .HBP_PCLK(HBP_PCLK), .HFP_PCLK(HFP_PCLK)) u_chk (
    .i_clk(i_clk), .i_reset(i_reset), .o_pclk(o_pclk), .o_video(o_video), .o_system_reset_low(o_system_reset_low));

// >>> tb/pvt_device_model.sv
/* Receiving device: samples video on pixel clock rise, counts pixels and lines.
   Assumes the source's pixel clock and device reset pins. */
module pvt_device_model
    import pvt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_pclk,
    input wire logic i_system_reset_low,
    input wire pvt_video_t i_video,
    output logic [11:0] o_line_px,
    output logic [11:0] o_frame_ln,
    output logic [11:0] o_err
);
    logic p_q, v_q, f_q;
    logic [11:0] px;
    logic [23:0] d_q;
    always_ff @(posedge i_clk) begin
        p_q <= i_pclk;
        if (!i_system_reset_low) begin
            {v_q, f_q, px, d_q, o_line_px, o_frame_ln, o_err} <= '0;
        end else if (i_pclk && !p_q) begin
            v_q <= i_video.pixel_valid_command;
            f_q <= i_video.frame_sync;
            d_q <= i_video.pixel_data;
            if (i_video.pixel_valid_command) begin
                px <= px + 12'h1;
                if (v_q && i_video.pixel_data !== d_q + 24'h1) o_err <= o_err + 12'h1;
            end
            if (v_q && !i_video.pixel_valid_command) begin
                o_line_px <= px;
                px <= '0;
                o_frame_ln <= o_frame_ln + 12'h1;
            end
            if (i_video.frame_sync && !f_q) o_frame_ln <= '0;
        end
    end
endmodule : pvt_device_model

// >>> tb/pvt_source_tb.sv
/* Testbench for pvt_source driving a device model.
   Assumes a 100 MHz clock and no software registers. */
module pvt_source_tb
    import pvt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_reset = 1, i_enable = 0;
    logic [23:0] i_pixel_data = '0;
    logic o_pixel_ready, o_pclk, o_system_reset_low, o_frame_start, o_timing_error;
    pvt_video_t o_video;
    logic [11:0] line_px, frame_ln, err;
    int error_cnt = 0, check_count = 0, cyc = 0;
    pvt_source uut (.i_clk(i_clk), .i_reset(i_reset), .i_enable(i_enable), .i_pixel_data(i_pixel_data),
        .o_pixel_ready(o_pixel_ready), .o_pclk(o_pclk), .o_video(o_video),
        .o_system_reset_low(o_system_reset_low), .o_frame_start(o_frame_start), .o_timing_error(o_timing_error));
    pvt_device_model u_dev (.i_clk(i_clk), .i_pclk(o_pclk), .i_system_reset_low(o_system_reset_low),
        .i_video(o_video), .o_line_px(line_px), .o_frame_ln(frame_ln), .o_err(err));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_pixel_ready === 1'b1) i_pixel_data <= i_pixel_data + 24'h1;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task print_verdict();
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task cyc_n(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc_n
    task wait_fs();
        int n;
        n = 0;
        while (o_frame_start !== 1'b1 && n < 12000) begin
            cyc_n(1);
            n++;
        end
        chk(12'(n < 12000), 12'h1);
    endtask : wait_fs
    task t_reset();
        @(posedge i_clk) i_reset <= 1;
        cyc_n(3);
        chk(12'({o_pclk, o_video != '0, o_system_reset_low}), 12'h0);
        @(posedge i_clk) i_reset <= 0;
        cyc_n(120);
        chk(12'(o_system_reset_low), 12'h0);
        cyc_n(10);
        chk(12'(o_system_reset_low), 12'h1);
    endtask : t_reset
    task t_frames();
        @(posedge i_clk) i_enable <= 1;
        wait_fs();
        cyc_n(10300);
        chk(line_px, 12'(DEF_ACTIVE_PIXELS));
        chk(frame_ln, 12'(DEF_ACTIVE_LINES));
        chk(err, 12'h0);
        chk(12'(o_timing_error), 12'h0);
    endtask : t_frames
    task t_stop();
        int k;
        k = 0;
        wait_fs();
        cyc_n(3000);
        @(posedge i_clk) i_enable <= 0;
        cyc_n(7500);
        chk(frame_ln, 12'(DEF_ACTIVE_LINES));
        repeat (12000) begin
            cyc_n(1);
            if (o_frame_start === 1'b1) k++;
        end
        chk(12'(k), 12'h0);
    endtask : t_stop
    initial begin
        t_reset();
        t_frames();
        t_stop();
        @(posedge i_clk) i_enable <= 1;
        wait_fs();
        cyc_n(500);
        t_reset();
        t_frames();
        print_verdict();
    end
endmodule : pvt_source_tb
